// ===== fcs_link_model.sv
// link-side model: drives request and clock of one synchronous burst read
`timescale 1ns/100ps
`default_nettype none
module fcs_link_model (
  input wire logic start_in,
  input wire logic [7:0] beats_in,
  output logic burst_clk_out,
  output logic burst_req_out,
  output logic [7:0] beat_out,
  output logic done_out
);
  initial begin
    burst_clk_out = 1'b0;
    burst_req_out = 1'b0;
    beat_out = 8'h00;
    done_out = 1'b0;
    forever begin
      wait (start_in);
      beat_out = 8'h00;
      burst_req_out = 1'b1;
      // odd offset keeps link edges clear of system clock edges
      #23;
      repeat (beats_in) begin
        #32 burst_clk_out = 1'b1;
        beat_out = beat_out + 8'h01;
        #32 burst_clk_out = 1'b0;
      end
      // clock stands still low outside the frame
      #40 burst_req_out = 1'b0;
      done_out = 1'b1;
      wait (!start_in);
      done_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== fcs_pkg.sv
// constants of the flash command decoder and configuration block
package fcs_pkg;
  localparam logic [15:0] ADDR_CMD = 16'hF220;
  localparam logic [15:0] ADDR_CFG1 = 16'hF221;
  localparam logic [15:0] ADDR_CFG2 = 16'hF222;
  localparam logic [15:0] ADDR_STATUS = 16'hF240;
  localparam logic [15:0] ADDR_FLAG = 16'hF241;
  localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
  localparam logic [15:0] CFG1_RESET = 16'h40C0;
  localparam int CFG_MODE_BIT = 15;
  localparam int CFG_LAT_LSB = 12;
  localparam int CFG_LEN_LSB = 9;
  localparam int CFG_ECC_BIT = 8;
  localparam int CFG_SPOL_BIT = 7;
  localparam int CFG_IPOL_BIT = 6;
  localparam int CFG_OE_BIT = 5;
  localparam int CFG_SCONF_BIT = 4;
  localparam int ST_ONGO_BIT = 15;
  localparam int ST_ERR_BIT = 10;
  localparam int ST_SUS_BIT = 9;
  localparam int ST_RSTB_BIT = 7;
  localparam int FLAG_BIT = 15;
  localparam logic FLAG_RESET = 1'b1;
  localparam logic [15:0] CMD_LOAD_MAIN = 16'h0000;
  localparam logic [15:0] CMD_LOAD_SPARE = 16'h0013;
  localparam logic [15:0] CMD_PROG_MAIN = 16'h0080;
  localparam logic [15:0] CMD_PROG_SPARE = 16'h001A;
  localparam logic [15:0] CMD_COPY_BACK = 16'h001B;
  localparam logic [15:0] CMD_UNLOCK = 16'h0023;
  localparam logic [15:0] CMD_LOCK = 16'h002A;
  localparam logic [15:0] CMD_LOCK_TIGHT = 16'h002C;
  localparam logic [15:0] CMD_ERASE_VERIFY = 16'h0071;
  localparam logic [15:0] CMD_ERASE_BLOCK = 16'h0094;
  localparam logic [15:0] CMD_ERASE_MULTI = 16'h0095;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] CMD_OTP = 16'h0065;
  localparam logic [15:0] CMD_RESET_CORE = 16'h00F0;
  localparam logic [15:0] CMD_RESET_HOT = 16'h00F3;
  localparam int CLK_PERIOD_NS = 8;
  localparam int OP_TIME_NS = 2000;
  localparam int LOCK_TIME_NS = 200;
  localparam int RST_TIME_NS = 400;
  localparam logic [15:0] OP_CYCLES = 16'((OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] LOCK_CYCLES = 16'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RST_CYCLES = 16'((RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY_RST_OK = 3'b010,
    ST_BUSY_LOCKED = 3'b100
  } fcs_state_t;
endpackage

// ===== fcs_top.sv
// flash command decoder, system configuration and ready/interrupt pins
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fcs_top
  import fcs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic op_fail_in,
  input wire logic warm_reset_pin_n_in,
  input wire logic burst_clk_in,
  input wire logic burst_req_in,
  output logic burst_valid_out,
  output logic read_mode_select_out,
  output logic ecc_bypass_out,
  output logic irq_pin_out,
  output logic irq_pin_oe_out,
  output logic strobe_pin_out,
  output logic strobe_pin_oe_out
);
  typedef struct packed {
    fcs_state_t state;
    logic [15:0] cmd;
    logic read_mode_select;
    logic [2:0] burst_latency;
    logic [2:0] burst_length_sel;
    logic ecc_bypass;
    logic strobe_polarity, irq_pin_polarity, pin_output_enable, strobe_conf;
    logic flag, err, sus, rstb, erase_op, array_op;
    logic [15:0] op_cnt, saved_cnt;
    logic wr_s1, wr_s2, bc_s1, bc_s2, bc_d, rq_s1, rq_s2;
    logic [6:0] beat;
    logic valid, irq_pin, strobe_pin;
    logic [15:0] rdata;
  } fcs_regs_t;

  fcs_regs_t s, next_s;
  logic cmd_wr, busy, op_done, strobe;
  logic [6:0] lat, len, thr;
  // unsupported latency codes (below 3) fall back to four cycles
  function automatic logic [6:0] latency_cycles(input logic [2:0] code);
    latency_cycles = (code < 3'h3) ? 7'h04 : {4'h0, code};
  endfunction

  // zero means continuous; reserved codes are treated as continuous
  function automatic logic [6:0] burst_words(input logic [2:0] code);
    unique case (code)
      3'h1: burst_words = 7'h04;
      3'h2: burst_words = 7'h08;
      3'h3: burst_words = 7'h10;
      3'h4: burst_words = 7'h20;
      default: burst_words = 7'h00;
    endcase
  endfunction

  function automatic logic code_known(input logic [15:0] c);
    unique case (c)
      CMD_LOAD_MAIN, CMD_LOAD_SPARE, CMD_PROG_MAIN, CMD_PROG_SPARE, CMD_COPY_BACK,
      CMD_UNLOCK, CMD_LOCK, CMD_LOCK_TIGHT, CMD_ERASE_VERIFY, CMD_ERASE_BLOCK,
      CMD_ERASE_MULTI, CMD_OTP, CMD_RESET_CORE, CMD_RESET_HOT: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction

  assign cmd_wr = wr_in && (addr_in == ADDR_CMD);
  assign busy = (s.state != ST_IDLE);
  assign op_done = busy && (s.op_cnt == 16'h0001);
  assign lat = latency_cycles(s.burst_latency);
  assign len = burst_words(s.burst_length_sel);
  // strobe window leads the data window by one link clock beat unless configured
  assign thr = s.strobe_conf ? lat : lat - 7'h01;
  assign strobe = !s.read_mode_select ||
                  (s.rq_s2 && (s.beat >= thr) && ((len == 7'h00) || (s.beat < thr + len)));

  always_comb begin
    logic req_rst;
    logic req_hot;
    next_s = s;
    req_rst = 1'b0;
    req_hot = 1'b0;
    next_s.wr_s1 = warm_reset_pin_n_in;
    next_s.wr_s2 = s.wr_s1;
    next_s.bc_s1 = burst_clk_in;
    next_s.bc_s2 = s.bc_s1;
    next_s.bc_d = s.bc_s2;
    next_s.rq_s1 = burst_req_in;
    next_s.rq_s2 = s.rq_s1;
    if (wr_in && addr_in == ADDR_FLAG) begin
      next_s.flag = wdata_in[FLAG_BIT];
    end
    if (wr_in && addr_in == ADDR_CFG1) begin
      next_s.read_mode_select = wdata_in[CFG_MODE_BIT];
      next_s.burst_latency = wdata_in[CFG_LAT_LSB +: 3];
      next_s.burst_length_sel = wdata_in[CFG_LEN_LSB +: 3];
      next_s.ecc_bypass = wdata_in[CFG_ECC_BIT];
      next_s.strobe_polarity = wdata_in[CFG_SPOL_BIT];
      next_s.irq_pin_polarity = wdata_in[CFG_IPOL_BIT];
      next_s.pin_output_enable = wdata_in[CFG_OE_BIT];
      next_s.strobe_conf = wdata_in[CFG_SCONF_BIT];
    end
    if (cmd_wr) begin
      next_s.cmd = wdata_in;
    end
    if (busy) begin
      next_s.op_cnt = s.op_cnt - 16'h0001;
    end
    unique case (s.state)
      ST_IDLE: begin
        if (cmd_wr) begin
          next_s.err = 1'b0;
          case (wdata_in)
            CMD_LOAD_MAIN, CMD_LOAD_SPARE, CMD_PROG_MAIN, CMD_PROG_SPARE,
            CMD_COPY_BACK, CMD_ERASE_VERIFY, CMD_OTP: begin
              next_s.state = ST_BUSY_RST_OK;
              next_s.op_cnt = OP_CYCLES;
              next_s.erase_op = 1'b0;
              next_s.array_op = 1'b1;
            end
            CMD_ERASE_BLOCK, CMD_ERASE_MULTI: begin
              next_s.state = ST_BUSY_RST_OK;
              next_s.op_cnt = OP_CYCLES;
              next_s.erase_op = 1'b1;
              next_s.array_op = 1'b1;
              next_s.sus = 1'b0;
            end
            CMD_UNLOCK, CMD_LOCK, CMD_LOCK_TIGHT: begin
              next_s.state = ST_BUSY_LOCKED;
              next_s.op_cnt = LOCK_CYCLES;
              next_s.array_op = 1'b0;
            end
            CMD_RESET_CORE: req_rst = 1'b1;
            CMD_RESET_HOT: req_hot = 1'b1;
            default: begin
              if (wdata_in == CMD_RESUME && s.sus) begin
                next_s.state = ST_BUSY_RST_OK;
                next_s.op_cnt = s.saved_cnt;
                next_s.erase_op = 1'b1;
                next_s.array_op = 1'b1;
                next_s.sus = 1'b0;
              end else begin
                // invalid code finishes at once with error
                next_s.err = 1'b1;
                next_s.flag = 1'b1;
              end
            end
          endcase
        end
      end
      ST_BUSY_RST_OK: begin
        // only reset codes, plus suspend of an erase
        if (cmd_wr && wdata_in == CMD_RESET_CORE) begin
          req_rst = 1'b1;
        end else if (cmd_wr && wdata_in == CMD_RESET_HOT) begin
          req_hot = 1'b1;
        end else if (cmd_wr && wdata_in == CMD_SUSPEND && s.erase_op) begin
          next_s.saved_cnt = s.op_cnt;
          next_s.sus = 1'b1;
          next_s.erase_op = 1'b0;
          next_s.array_op = 1'b0;
          next_s.state = ST_BUSY_LOCKED;
          next_s.op_cnt = LOCK_CYCLES;
        end else if (op_done) begin
          next_s.state = ST_IDLE;
          next_s.flag = 1'b1;
          next_s.err = op_fail_in;
          next_s.erase_op = 1'b0;
        end
      end
      ST_BUSY_LOCKED: begin
        if (op_done) begin
          next_s.state = ST_IDLE;
          next_s.flag = 1'b1;
          next_s.err = s.array_op & op_fail_in;
          next_s.rstb = 1'b0;
        end
      end
    endcase
    // warm reset pin is level sensitive and held while low
    if (!s.wr_s2) begin
      req_hot = 1'b1;
    end
    if (req_hot) begin
      // hot reset restores defaults, keeps output enable
      next_s.read_mode_select = CFG1_RESET[CFG_MODE_BIT];
      next_s.burst_latency = CFG1_RESET[CFG_LAT_LSB +: 3];
      next_s.burst_length_sel = CFG1_RESET[CFG_LEN_LSB +: 3];
      next_s.ecc_bypass = CFG1_RESET[CFG_ECC_BIT];
      next_s.strobe_polarity = CFG1_RESET[CFG_SPOL_BIT];
      next_s.irq_pin_polarity = CFG1_RESET[CFG_IPOL_BIT];
      next_s.strobe_conf = CFG1_RESET[CFG_SCONF_BIT];
      next_s.cmd = CMD_RESET_VAL;
      next_s.err = 1'b0;
    end
    if (req_rst || req_hot) begin
      // reset runs as a busy operation taking no command
      next_s.state = ST_BUSY_LOCKED;
      next_s.op_cnt = RST_CYCLES;
      next_s.rstb = 1'b1;
      next_s.sus = 1'b0;
      next_s.erase_op = 1'b0;
      next_s.array_op = 1'b0;
      next_s.flag = 1'b0;
    end
    // beats counted on rising link clock edges after the request
    if (!s.rq_s2 || !s.read_mode_select) begin
      next_s.beat = 7'h00;
    end else if (s.bc_s2 && !s.bc_d && s.beat != 7'h7F) begin
      next_s.beat = s.beat + 7'h01;
    end
    // data window closes after the burst length
    next_s.valid = s.read_mode_select && s.rq_s2 && (s.beat >= lat) &&
                   ((len == 7'h00) || (s.beat < lat + len));
    next_s.strobe_pin = s.strobe_polarity ? strobe : !strobe;
    // interrupt pin follows or inverts the flag
    next_s.irq_pin = s.irq_pin_polarity ? s.flag : !s.flag;
    next_s.rdata = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_CMD: next_s.rdata = s.cmd;
        // protect bit and reserved bits read zero
        ADDR_CFG1: next_s.rdata = {s.read_mode_select, s.burst_latency, s.burst_length_sel,
                                   s.ecc_bypass, s.strobe_polarity, s.irq_pin_polarity,
                                   s.pin_output_enable, s.strobe_conf, 4'h0};
        ADDR_STATUS: begin
          next_s.rdata[ST_ONGO_BIT] = busy;
          next_s.rdata[ST_ERR_BIT] = s.err;
          next_s.rdata[ST_SUS_BIT] = s.sus;
          next_s.rdata[ST_RSTB_BIT] = s.rstb;
        end
        ADDR_FLAG: next_s.rdata[FLAG_BIT] = s.flag;
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.cmd <= CMD_RESET_VAL;
      s.burst_latency <= CFG1_RESET[CFG_LAT_LSB +: 3];
      s.strobe_polarity <= CFG1_RESET[CFG_SPOL_BIT];
      s.irq_pin_polarity <= CFG1_RESET[CFG_IPOL_BIT];
      s.flag <= FLAG_RESET;
      s.wr_s1 <= 1'b1;
      s.wr_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign burst_valid_out = s.valid;
  assign read_mode_select_out = s.read_mode_select;
  assign ecc_bypass_out = s.ecc_bypass;
  assign irq_pin_out = s.irq_pin;
  assign strobe_pin_out = s.strobe_pin;
  assign irq_pin_oe_out = s.pin_output_enable;
  assign strobe_pin_oe_out = s.pin_output_enable;
  default clocking sys_cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_idle_cmd(logic [15:0] c);
    s.state == ST_IDLE && cmd_wr && wdata_in == c && s.wr_s2;
  endsequence
  sequence s_run_op;
    s.state == ST_BUSY_RST_OK && s.op_cnt == OP_CYCLES;
  endsequence
  property p_done_ready;
    op_done && !cmd_wr && s.wr_s2 |=> s.flag && s.state == ST_IDLE;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("flag not ready after op");
  property p_load;
    s_idle_cmd(CMD_LOAD_SPARE) |=> s_run_op ##1 s.op_cnt == OP_CYCLES - 16'h0001;
  endproperty
  a_load: assert property (p_load) else $error("load did not start");
  property p_prog;
    s_idle_cmd(CMD_PROG_SPARE) |=> s_run_op and !s.erase_op;
  endproperty
  a_prog: assert property (p_prog) else $error("program did not start");
  property p_lock;
    s_idle_cmd(CMD_LOCK_TIGHT) |=> s.state == ST_BUSY_LOCKED && s.op_cnt == LOCK_CYCLES;
  endproperty
  a_lock: assert property (p_lock) else $error("lock did not start");
  property p_erase;
    s_idle_cmd(CMD_ERASE_MULTI) |=> s_run_op and s.erase_op;
  endproperty
  a_erase: assert property (p_erase) else $error("erase did not start");
  property p_suspend;
    s.state == ST_BUSY_RST_OK && s.erase_op && cmd_wr && wdata_in == CMD_SUSPEND && s.wr_s2
    |=> s.sus && s.saved_cnt == $past(s.op_cnt);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend lost erase");
  property p_hot;
    s_idle_cmd(CMD_RESET_HOT) |=> s.rstb && !s.flag && s.burst_latency == CFG1_RESET[CFG_LAT_LSB +: 3];
  endproperty
  a_hot: assert property (p_hot) else $error("hot reset incomplete");
  property p_locked_busy;
    s.state == ST_BUSY_LOCKED && cmd_wr && !op_done && s.wr_s2 |=> s.op_cnt == $past(s.op_cnt) - 16'h0001;
  endproperty
  a_locked_busy: assert property (p_locked_busy) else $error("busy op disturbed");
  property p_oe_kept;
    s.pin_output_enable && !s.wr_s2 && !wr_in |=> s.pin_output_enable;
  endproperty
  a_oe_kept: assert property (p_oe_kept) else $error("warm reset cleared enable");
  property p_protect;
    rd_in && addr_in == ADDR_CFG1 |=> rdata_out[0] == 1'b0 && rdata_out[5] == s.pin_output_enable;
  endproperty
  a_protect: assert property (p_protect) else $error("protect bit not zero");
  property p_invalid;
    s.state == ST_IDLE && cmd_wr && s.wr_s2 && !code_known(wdata_in) && !(wdata_in == CMD_RESUME && s.sus)
    |=> s.err && s.flag && s.state == ST_IDLE;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid code not flagged");
  property p_ignore;
    s.state == ST_BUSY_RST_OK && cmd_wr && !op_done && s.wr_s2 && wdata_in[7:4] != 4'hF && wdata_in != CMD_SUSPEND
    |=> s.state == ST_BUSY_RST_OK;
  endproperty
  a_ignore: assert property (p_ignore) else $error("busy op disturbed by write");
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench of the flash command decoder and configuration block
`timescale 1ns/100ps
`default_nettype none
module tb
  import fcs_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic op_fail_in = 1'b0;
  logic warm_reset_pin_n_in = 1'b1;
  logic start = 1'b0;
  logic [7:0] beats = 8'h00;
  logic burst_clk_in, burst_req_in, done;
  logic [7:0] beat;
  logic [15:0] rdata_out;
  logic burst_valid_out, read_mode_select_out, ecc_bypass_out;
  logic irq_pin_out, irq_pin_oe_out, strobe_pin_out, strobe_pin_oe_out;
  int n_fail = 0;
  int checked = 0;
  int i;
  logic [15:0] arr [9] = '{CMD_LOAD_MAIN, CMD_LOAD_SPARE, CMD_PROG_MAIN, CMD_PROG_SPARE, CMD_COPY_BACK,
    CMD_ERASE_VERIFY, CMD_ERASE_BLOCK, CMD_ERASE_MULTI, CMD_OTP};
  logic [15:0] lck [3] = '{CMD_UNLOCK, CMD_LOCK, CMD_LOCK_TIGHT};
  logic [15:0] bad [2] = '{CMD_SUSPEND, 16'h0055};
  logic [2:0] bl [5] = '{3'h3, 3'h4, 3'h7, 3'h0, 3'h5};
  logic [2:0] bn [5] = '{3'h1, 3'h2, 3'h1, 3'h3, 3'h4};
  logic bc [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  fcs_top uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .op_fail_in(op_fail_in),
    .warm_reset_pin_n_in(warm_reset_pin_n_in), .burst_clk_in(burst_clk_in), .burst_req_in(burst_req_in),
    .burst_valid_out(burst_valid_out), .read_mode_select_out(read_mode_select_out),
    .ecc_bypass_out(ecc_bypass_out), .irq_pin_out(irq_pin_out), .irq_pin_oe_out(irq_pin_oe_out),
    .strobe_pin_out(strobe_pin_out), .strobe_pin_oe_out(strobe_pin_oe_out));

  fcs_link_model link (.start_in(start), .beats_in(beats), .burst_clk_out(burst_clk_in),
    .burst_req_out(burst_req_in), .beat_out(beat), .done_out(done));

  always #4 clk_sys_in = ~clk_sys_in;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] m, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d & m, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask

  // spare-area masking is left to the host; no buffer sits behind this block
  task automatic cmd(input logic [15:0] c);
    wr(ADDR_FLAG, 16'h0000);
    wr(ADDR_CMD, c);
  endtask

  task automatic wait_flag;
    logic [15:0] d;
    int k;
    d = 16'h0000;
    for (k = 0; k < 400 && d[FLAG_BIT] !== 1'b1; k++) rd(ADDR_FLAG, d);
    if (d[FLAG_BIT] !== 1'b1) begin
      $display("Error at %0t: completion flag never returned", $time);
      n_fail++;
      finish_test;
    end
  endtask

  // one frame; the window is measured in system cycles, eight per beat
  task automatic burst(input logic [2:0] lat, input logic [2:0] len, input logic conf);
    int lat_n, len_n, t, t_s, t_v, n_v;
    logic [7:0] b_v;
    lat_n = (lat < 3'h3) ? 4 : int'(lat);
    len_n = 2 << len;
    t_s = -1;
    t_v = -1;
    n_v = 0;
    b_v = 8'h00;
    wr(ADDR_CFG1, {1'b1, lat, len, 1'b0, 3'b111, conf, 4'h0});
    settle;
    @(posedge clk_sys_in);
    beats <= 8'(lat_n + len_n + 2);
    start <= 1'b1;
    for (t = 0; t < 3000 && done !== 1'b1; t++) begin
      @(posedge clk_sys_in);
      #1;
      if (strobe_pin_out === 1'b1 && t_s < 0) t_s = t;
      if (burst_valid_out === 1'b1) begin
        if (t_v < 0) b_v = beat;
        if (t_v < 0) t_v = t;
        n_v++;
      end
    end
    if (done !== 1'b1) begin
      $display("Error at %0t: burst frame never ended", $time);
      n_fail++;
      finish_test;
    end
    @(posedge clk_sys_in);
    start <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk(16'(b_v), 16'(lat_n));
    chk(16'(n_v), 16'(len_n * 8));
    chk(16'(t_v - t_s), conf ? 16'h0000 : 16'h0008);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rdc(ADDR_CFG1, 16'hFFFF, 16'h40C0);
    rdc(ADDR_CMD, 16'hFFFF, 16'h0000);
    rdc(ADDR_CFG2, 16'hFFFF, 16'h0000);
    rdc(16'h0100, 16'hFFFF, 16'h0000);
    chk({14'h0000, irq_pin_oe_out, strobe_pin_oe_out}, 16'h0000);
    wr(ADDR_CFG1, 16'hFFFF);
    rdc(ADDR_CFG1, 16'hFFFF, 16'hFFF0);
    settle;
    chk({12'h000, read_mode_select_out, ecc_bypass_out, irq_pin_oe_out, strobe_pin_oe_out}, 16'h000F);
    wr(ADDR_CFG1, 16'h40E0);
    settle;
    chk({12'h000, read_mode_select_out, ecc_bypass_out, strobe_pin_out, irq_pin_out}, 16'h0003);
    wr(ADDR_CFG1, 16'h4060);
    settle;
    chk({14'h0000, strobe_pin_out, irq_pin_out}, 16'h0001);
    wr(ADDR_CFG1, 16'h40A0);
    settle;
    chk({14'h0000, strobe_pin_out, irq_pin_out}, 16'h0002);
    wr(ADDR_FLAG, 16'h0000);
    settle;
    chk({14'h0000, strobe_pin_out, irq_pin_out}, 16'h0003);
    wr(ADDR_CFG1, 16'h40E0);
    for (i = 0; i < 9; i++) begin
      @(posedge clk_sys_in) op_fail_in <= (i == 4);
      cmd(arr[i]);
      rdc(ADDR_STATUS, 16'h8080, 16'h8000);
      chk({15'h0000, irq_pin_out}, 16'h0000);
      // a lock code mid-operation must not shorten the operation
      wr(ADDR_CMD, CMD_LOCK);
      repeat (40) @(posedge clk_sys_in);
      rdc(ADDR_STATUS, 16'h8080, 16'h8000);
      wait_flag;
      rdc(ADDR_STATUS, 16'h8400, {5'h00, (i == 4), 10'h000});
    end
    @(posedge clk_sys_in) op_fail_in <= 1'b0;
    for (i = 0; i < 3; i++) begin
      cmd(lck[i]);
      wr(ADDR_CMD, CMD_RESET_CORE);
      rdc(ADDR_STATUS, 16'h8080, 16'h8000);
      wait_flag;
    end
    cmd(CMD_PROG_MAIN);
    wr(ADDR_CMD, CMD_RESET_CORE);
    rdc(ADDR_STATUS, 16'h8080, 16'h8080);
    wait_flag;
    cmd(CMD_ERASE_BLOCK);
    wr(ADDR_CMD, CMD_SUSPEND);
    rdc(ADDR_STATUS, 16'h0200, 16'h0200);
    wait_flag;
    cmd(CMD_RESUME);
    rdc(ADDR_STATUS, 16'h8200, 16'h8000);
    wait_flag;
    for (i = 0; i < 2; i++) begin
      cmd(bad[i]);
      settle;
      rdc(ADDR_STATUS, 16'h8400, 16'h0400);
      rdc(ADDR_FLAG, 16'h8000, 16'h8000);
    end
    wr(ADDR_CFG1, 16'hB7F0);
    cmd(CMD_RESET_HOT);
    rdc(ADDR_STATUS, 16'h8080, 16'h8080);
    wait_flag;
    rdc(ADDR_CFG1, 16'hFFFF, 16'h40E0);
    wr(ADDR_CFG1, 16'h5320);
    warm_reset_pin_n_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rdc(ADDR_STATUS, 16'h8080, 16'h8080);
    @(posedge clk_sys_in) warm_reset_pin_n_in <= 1'b1;
    wait_flag;
    rdc(ADDR_CFG1, 16'hFFFF, 16'h40E0);
    wr(ADDR_CFG1, 16'h40C0);
    settle;
    chk({14'h0000, irq_pin_oe_out, strobe_pin_oe_out}, 16'h0000);
    for (i = 0; i < 5; i++) burst(bl[i], bn[i], bc[i]);
    finish_test;
  end
endmodule
`default_nettype wire
